// >>> src/i2c_flag_defines.vh
// Purpose: constants shared by the two-wire status flag logic
// Assumes: registers one byte each, one aligned word per register
// Notes:   offsets are word indices, byte address bits [7:2] on the register bus
`ifndef I2C_FLAG_DEFINES_VH
`define I2C_FLAG_DEFINES_VH

// register word index, taken from adr[7:2]
`define REG_IDX_W         6
`define REG_CTRL          6'h00
`define REG_STATUS_ONE    6'h01
`define REG_STATUS_TWO    6'h02
`define REG_DATA          6'h03

// control register fields
`define CTRL_IRQ_EN       0
`define CTRL_STOP         1
`define CTRL_ACK_EN       2
`define CTRL_START        3
`define CTRL_GCALL_EN     4
`define CTRL_IFACE_EN     5
`define CTRL_RESET        8'h00
`define CTRL_WMASK        8'h3f

// status one fields
`define S1_START_SENT     0
`define S1_ROLE           1
`define S1_ADDR_MATCH     2
`define S1_BYTE_DONE      3
`define S1_BUSY           4
`define S1_DIR_TX         5
`define S1_HEADER_SENT    6
`define S1_EVENT          7

// status two fields
`define S2_BUS_FAULT      1
`define S2_ARB_LOST       2
`define S2_STOP_SEEN      3
`define S2_ACK_MISSING    4

`define BYTE_ZERO         8'h00
`define WORD_ZERO         32'h0000_0000
`define PAD_ZERO          24'h00_0000

`endif

// >>> src/line_sync3.v
// Purpose: three-stage synchroniser with agreement filter for a bus line
// Assumes: line idles high
// Notes:   output follows only when stages two and three agree
`timescale 1ns/100ps

module line_sync3
(
  input  wire clk_i,
  input  wire rst_i,
  input  wire line_i,
  output reg  level_o
);

  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage1  <= 1'b1;
      stage2  <= 1'b1;
      stage3  <= 1'b1;
      level_o <= 1'b1;
    end
    else
    begin
      stage1 <= line_i;
      stage2 <= stage1;
      stage3 <= stage2;
      // stage1 feeds stage2 only; filter looks at later stages
      if (stage2 == stage3)
        level_o <= stage3;
    end
  end

endmodule

// >>> src/i2c_status_flag_logic.v
// Purpose: status flag logic of a two-wire serial bus interface
// Assumes: byte engine on clk_i reports byte, address and start events
// Notes:   wishbone classic slave; ack one cycle after the request
//
// Summary of operation
// - event flag set as soon as event occurs
// - event flag is OR of all event sources
// - error events clear on status two read
// - disable clears all flags except busy
// - header flag set after 10-bit header sent
// - header clears by status two read, data write
// - direction shows transmit, clears with byte done
// - direction clears on stop, arbitration loss, disable
// - busy set on start, cleared on stop
// - busy cleared on bus fault
// - busy frozen while interface disabled
// - byte done set on completed byte, interrupts
// - transmit byte done after ack clock pulse
// - receive byte done after driven ack, if enabled
// - byte done clears by status read, data access
// - clock held low while byte done
// - address match flag set, cleared on read
// - clock held low while address matched
// - role set on start request, cleared on stop
// - start sent flag set after start generated
// - start sent clears by status read, data write
// - one interrupt, gated by enable and mask
// - disable resets control except stop, releases bus
`timescale 1ns/100ps
`include "i2c_flag_defines.vh"

module i2c_status_flag_logic
(
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // bus lines
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         scl_o,
  output reg         scl_oe_o,
  // byte engine events, one-cycle pulses on clk_i
  input  wire        byte_tx_acked_i,
  input  wire        byte_rx_acked_i,
  input  wire        header_tx_i,
  input  wire        addr_match_i,
  input  wire        start_done_i,
  input  wire        stop_done_i,
  input  wire        ack_missing_i,
  input  wire        arb_lost_i,
  input  wire        misplaced_i,
  input  wire [7:0]  rx_byte_i,
  input  wire        global_mask_i,
  // to byte engine
  output reg  [7:0]  tx_byte_o,
  output reg         tx_load_o,
  output reg         rx_taken_o,
  output reg         start_req_o,
  output reg         stop_req_o,
  output reg         ack_enable_o,
  output reg         gcall_enable_o,
  output reg         iface_enable_o,
  output reg         irq_o
);

  reg  [7:0] ctrl;
  reg        event_pending;
  reg        header_sent;
  reg        direction_transmit;
  reg        bus_busy;
  reg        byte_done;
  reg        addr_matched;
  reg        controller_role;
  reg        start_sent;
  reg        ack_missing;
  reg        stop_seen;
  reg        arb_lost;
  reg        bus_fault;
  reg        one_read_seen;
  reg        two_read_seen;
  reg        scl_prev;
  reg        sda_prev;

  wire       scl_level;
  wire       sda_level;

  line_sync3 u_scl_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .line_i  (scl_i),
    .level_o (scl_level)
  );

  line_sync3 u_sda_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .line_i  (sda_i),
    .level_o (sda_level)
  );

  // start: data falls while clock high; stop: data rises while clock high
  wire start_det = scl_level & scl_prev & sda_prev & ~sda_level;
  wire stop_det  = scl_level & scl_prev & ~sda_prev & sda_level;

  wire enable    = ctrl[`CTRL_IFACE_EN];

  // bus access decode
  wire                  req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [`REG_IDX_W-1:0] idx     = wb_adr_i[7:2];
  wire                  lane0   = wb_sel_i[0];
  wire                  wr      = req & wb_we_i & lane0;
  wire                  rd      = req & ~wb_we_i;
  wire                  ctrl_wr = wr & (idx == `REG_CTRL);
  wire                  one_rd  = rd & (idx == `REG_STATUS_ONE);
  wire                  two_rd  = rd & (idx == `REG_STATUS_TWO);
  wire                  data_wr = wr & (idx == `REG_DATA);
  wire                  data_rd = rd & (idx == `REG_DATA);

  // event qualification
  wire ev_tx     = enable & byte_tx_acked_i;
  wire ev_rx     = enable & byte_rx_acked_i & ctrl[`CTRL_ACK_EN];
  wire ev_hdr    = enable & header_tx_i & controller_role;
  wire ev_match  = enable & addr_match_i;
  wire ev_start  = enable & start_done_i & ctrl[`CTRL_START];
  wire ev_nack   = enable & ack_missing_i;
  wire ev_stop   = enable & stop_det;
  wire ev_arb    = enable & arb_lost_i;
  wire ev_fault  = enable & misplaced_i;

  wire byte_clear = one_read_seen &
                    (direction_transmit ? data_wr : data_rd);

  reg  [7:0] next_ctrl;
  reg        next_header_sent;
  reg        next_direction_transmit;
  reg        next_bus_busy;
  reg        next_byte_done;
  reg        next_addr_matched;
  reg        next_controller_role;
  reg        next_start_sent;
  reg        next_ack_missing;
  reg        next_stop_seen;
  reg        next_arb_lost;
  reg        next_bus_fault;
  reg        next_event_pending;
  reg [31:0] next_rdata;

  always @*
  begin
    // control register
    next_ctrl = ctrl;
    if (ctrl_wr)
      next_ctrl = wb_dat_i[7:0] & `CTRL_WMASK;
    if (ev_start)
      next_ctrl[`CTRL_START] = 1'b0;
    if (stop_done_i & controller_role)
      next_ctrl[`CTRL_STOP] = 1'b0;
    if (!next_ctrl[`CTRL_IFACE_EN])
    begin
      // stop bit survives a disable
      next_ctrl = `CTRL_RESET;
      next_ctrl[`CTRL_STOP] = ctrl_wr ? wb_dat_i[`CTRL_STOP]
                                      : ctrl[`CTRL_STOP];
    end

    // status one: clears first, sets after so a set wins
    next_header_sent = header_sent;
    if (data_wr & two_read_seen)
      next_header_sent = 1'b0;
    if (ev_hdr)
      next_header_sent = 1'b1;

    next_byte_done = byte_done;
    if (byte_clear)
      next_byte_done = 1'b0;
    if (ev_tx | ev_rx)
      next_byte_done = 1'b1;

    next_direction_transmit = direction_transmit;
    if (byte_clear | ev_stop | ev_arb)
      next_direction_transmit = 1'b0;
    if (ev_tx)
      next_direction_transmit = 1'b1;
    else if (ev_rx)
      next_direction_transmit = 1'b0;

    next_addr_matched = addr_matched;
    if (one_rd)
      next_addr_matched = 1'b0;
    if (ev_match)
      next_addr_matched = 1'b1;

    next_controller_role = controller_role;
    if (ev_stop | ev_arb)
      next_controller_role = 1'b0;
    if (ctrl_wr & wb_dat_i[`CTRL_START] & enable)
      next_controller_role = 1'b1;

    next_start_sent = start_sent;
    if (data_wr & one_read_seen)
      next_start_sent = 1'b0;
    if (ev_start)
      next_start_sent = 1'b1;

    // busy tracks the bus only while enabled
    next_bus_busy = bus_busy;
    if (enable)
    begin
      if (stop_det | misplaced_i)
        next_bus_busy = 1'b0;
      if (start_det)
        next_bus_busy = 1'b1;
    end

    // status two error flags, cleared by reading status two
    next_ack_missing = ack_missing;
    next_stop_seen   = stop_seen;
    next_arb_lost    = arb_lost;
    next_bus_fault   = bus_fault;
    if (two_rd)
    begin
      next_ack_missing = 1'b0;
      next_stop_seen   = 1'b0;
      next_arb_lost    = 1'b0;
      next_bus_fault   = 1'b0;
    end
    if (ev_nack)
      next_ack_missing = 1'b1;
    if (ev_stop & ~controller_role & ctrl[`CTRL_ACK_EN])
      next_stop_seen = 1'b1;
    if (ev_arb)
      next_arb_lost = 1'b1;
    if (ev_fault)
      next_bus_fault = 1'b1;

    if (!next_ctrl[`CTRL_IFACE_EN])
    begin
      next_header_sent        = 1'b0;
      next_byte_done          = 1'b0;
      next_direction_transmit = 1'b0;
      next_addr_matched       = 1'b0;
      next_controller_role    = 1'b0;
      next_start_sent         = 1'b0;
      next_ack_missing        = 1'b0;
      next_stop_seen          = 1'b0;
      next_arb_lost           = 1'b0;
      next_bus_fault          = 1'b0;
    end

    next_event_pending = next_byte_done | next_addr_matched |
                         next_start_sent | next_ack_missing |
                         next_stop_seen | next_arb_lost |
                         next_bus_fault | next_header_sent;

    // read data, sampled before the clears of this access
    next_rdata = `WORD_ZERO;
    case (idx)
      `REG_CTRL:
        next_rdata = {`PAD_ZERO, ctrl};
      `REG_STATUS_ONE:
        next_rdata = {`PAD_ZERO, event_pending, header_sent,
                      direction_transmit, bus_busy, byte_done,
                      addr_matched, controller_role, start_sent};
      `REG_STATUS_TWO:
        next_rdata = {`PAD_ZERO, 3'b000, ack_missing, stop_seen,
                      arb_lost, bus_fault, 1'b0};
      `REG_DATA:
        next_rdata = {`PAD_ZERO, rx_byte_i};
      default:
        next_rdata = `WORD_ZERO;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl               <= `CTRL_RESET;
      event_pending      <= 1'b0;
      header_sent        <= 1'b0;
      direction_transmit <= 1'b0;
      bus_busy           <= 1'b0;
      byte_done          <= 1'b0;
      addr_matched       <= 1'b0;
      controller_role    <= 1'b0;
      start_sent         <= 1'b0;
      ack_missing        <= 1'b0;
      stop_seen          <= 1'b0;
      arb_lost           <= 1'b0;
      bus_fault          <= 1'b0;
      one_read_seen      <= 1'b0;
      two_read_seen      <= 1'b0;
      scl_prev           <= 1'b1;
      sda_prev           <= 1'b1;
      wb_ack_o           <= 1'b0;
      wb_dat_o           <= `WORD_ZERO;
      scl_o              <= 1'b0;
      scl_oe_o           <= 1'b0;
      tx_byte_o          <= `BYTE_ZERO;
      tx_load_o          <= 1'b0;
      rx_taken_o         <= 1'b0;
      start_req_o        <= 1'b0;
      stop_req_o         <= 1'b0;
      ack_enable_o       <= 1'b0;
      gcall_enable_o     <= 1'b0;
      iface_enable_o     <= 1'b0;
      irq_o              <= 1'b0;
    end
    else
    begin
      ctrl               <= next_ctrl;
      event_pending      <= next_event_pending;
      header_sent        <= next_header_sent;
      direction_transmit <= next_direction_transmit;
      bus_busy           <= next_bus_busy;
      byte_done          <= next_byte_done;
      addr_matched       <= next_addr_matched;
      controller_role    <= next_controller_role;
      start_sent         <= next_start_sent;
      ack_missing        <= next_ack_missing;
      stop_seen          <= next_stop_seen;
      arb_lost           <= next_arb_lost;
      bus_fault          <= next_bus_fault;
      scl_prev           <= scl_level;
      sda_prev           <= sda_level;

      // clear sequences need the status read first, then a data access
      if (data_wr | data_rd | !next_ctrl[`CTRL_IFACE_EN])
        one_read_seen <= 1'b0;
      else if (one_rd)
        one_read_seen <= 1'b1;
      if (data_wr | data_rd | !next_ctrl[`CTRL_IFACE_EN])
        two_read_seen <= 1'b0;
      else if (two_rd)
        two_read_seen <= 1'b1;

      wb_ack_o <= req;
      if (rd)
        wb_dat_o <= next_rdata;

      if (data_wr)
        tx_byte_o <= wb_dat_i[7:0];
      tx_load_o  <= data_wr;
      rx_taken_o <= data_rd;

      // stretch while software owes an answer; released when disabled
      scl_o    <= 1'b0;
      scl_oe_o <= next_ctrl[`CTRL_IFACE_EN] &
                  (next_byte_done | next_addr_matched |
                   next_start_sent | next_header_sent);

      start_req_o    <= next_ctrl[`CTRL_START];
      stop_req_o     <= next_ctrl[`CTRL_STOP];
      ack_enable_o   <= next_ctrl[`CTRL_ACK_EN];
      gcall_enable_o <= next_ctrl[`CTRL_GCALL_EN];
      iface_enable_o <= next_ctrl[`CTRL_IFACE_EN];

      // single vector for all events
      irq_o <= next_event_pending & next_ctrl[`CTRL_IRQ_EN] &
               ~global_mask_i;
    end
  end

endmodule

// >>> tb/bus_line_model.sv
// Purpose: far-side model of the two bus lines, both with pull-up
// Assumes: link clock half period of 160 ns
// Notes:   frames only start and stop, no data bits
`timescale 1ns/100ps

module bus_line_model
(
  input  wire stretch_i,
  output wire scl_o,
  output wire sda_o
);
  reg scl_drv;
  reg sda_drv;

  // wired-and: the block may hold the clock low at any time
  assign scl_o = scl_drv & ~stretch_i;
  assign sda_o = sda_drv;

  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // data falls while clock is high
  // non-blocking so a change landing on a core clock edge cannot race
  task start_cond;
  begin
    #160 sda_drv <= 1'b0;
    #160 scl_drv <= 1'b0;
  end
  endtask

  // data rises while clock is high
  task stop_cond;
  begin
    #160 scl_drv <= 1'b1;
    #160 sda_drv <= 1'b1;
  end
  endtask
endmodule

// >>> tb/i2c_flag_checker.sv
// Purpose: port-level checks on the status flag logic
// Assumes: one clock domain, ack one cycle after a taken request
// Notes:   flags show only through stretch, irq and register reads
`timescale 1ns/100ps

module i2c_flag_checker
(
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        scl_oe_o,
  input wire        byte_tx_acked_i,
  input wire        byte_rx_acked_i,
  input wire        addr_match_i,
  input wire [7:0]  rx_byte_i,
  input wire        global_mask_i,
  input wire [7:0]  tx_byte_o,
  input wire        tx_load_o,
  input wire        rx_taken_o,
  input wire        ack_enable_o,
  input wire        iface_enable_o,
  input wire        irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence dwr_s;
    take_s ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h03);
  endsequence
  sequence drd_s;
    take_s ##0 (!wb_we_i && wb_adr_i[7:2] == 6'h03);
  endsequence
  // no register access can clear a flag in this cycle
  sequence quiet_s;
    iface_enable_o && !wb_cyc_i;
  endsequence

  AST_ACK_NEXT:
    assert property (take_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one pulse after request");
  AST_TX_LOAD:
    assert property (dwr_s |=> tx_load_o && tx_byte_o == $past(wb_dat_i[7:0]))
    else $error("data write not handed on");
  AST_RX_READ:
    assert property (drd_s |=> rx_taken_o && wb_dat_o[7:0] == $past(rx_byte_i))
    else $error("data read not returned");
  AST_TX_STRETCH:
    assert property (byte_tx_acked_i ##0 quiet_s |=> scl_oe_o)
    else $error("no stretch after sent byte");
  AST_RX_STRETCH:
    assert property (byte_rx_acked_i && ack_enable_o ##0 quiet_s |=> scl_oe_o)
    else $error("no stretch after received byte");
  AST_MATCH_STRETCH:
    assert property (addr_match_i ##0 quiet_s |=> scl_oe_o)
    else $error("no stretch after address match");
  AST_STRETCH_HOLD:
    assert property (scl_oe_o && !wb_cyc_i |=> scl_oe_o)
    else $error("stretch dropped without access");
  AST_IRQ_MASK:
    assert property (irq_o |-> !$past(global_mask_i))
    else $error("irq while masked");
  AST_OFF_QUIET:
    assert property (!iface_enable_o && !$past(iface_enable_o) |->
                     !scl_oe_o && !irq_o)
    else $error("flag active while disabled");
endmodule

// >>> tb/i2c_status_flag_logic_tb.sv
// Purpose: self-checking bench for the status flag logic
// Assumes: map 00 ctrl, 04 status one, 08 status two, 0c data
// Notes:   engine events are one-cycle pulses made here
`timescale 1ns/100ps

module i2c_status_flag_logic_tb;
  reg         clk_i;
  reg         rst_i;
  reg         cyc;
  reg         we;
  reg  [7:0]  adr;
  reg  [31:0] dat;
  reg  [8:0]  ev;
  reg  [7:0]  rx_byte;
  reg         mask;
  reg  [7:0]  q;
  wire [31:0] rdat;
  wire        ack;
  wire        scl_line;
  wire        sda_line;
  wire        scl_o;
  wire        scl_oe_o;
  wire        irq_o;
  wire        start_req;
  wire        stop_req;
  wire        gcall_en;
  integer     miscompares;
  integer     total_checks;

  i2c_status_flag_logic i2c_status_flag_logic_inst
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl_line),
    .sda_i(sda_line), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .byte_tx_acked_i(ev[0]), .byte_rx_acked_i(ev[1]),
    .header_tx_i(ev[2]), .addr_match_i(ev[3]), .start_done_i(ev[4]),
    .stop_done_i(ev[5]), .ack_missing_i(ev[6]), .arb_lost_i(ev[7]),
    .misplaced_i(ev[8]), .rx_byte_i(rx_byte), .global_mask_i(mask),
    .tx_byte_o(), .tx_load_o(), .rx_taken_o(),
    .start_req_o(start_req), .stop_req_o(stop_req), .ack_enable_o(),
    .gcall_enable_o(gcall_en),
    .iface_enable_o(), .irq_o(irq_o)
  );

  bus_line_model bus_line_model_inst
  (
    .stretch_i(scl_oe_o & ~scl_o),
    .scl_o(scl_line),
    .sda_o(sda_line)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task stop_test;
  begin
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  task chk(input string name, input [7:0] exp, input [7:0] got);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  end
  endtask

  task wb(input w, input [7:0] a, input [7:0] d);
  begin
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    // no limit here: a hung request is ended by the watchdog
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
  end
  endtask

  task s1(input [7:0] exp);
  begin
    wb(1'b0, 8'h04, 8'h00);
    chk("status_one", exp, q);
  end
  endtask

  task pulse(input integer k);
  begin
    @(posedge clk_i);
    ev[k] <= 1'b1;
    @(posedge clk_i);
    ev <= 9'h000;
  end
  endtask

  // filtered line needs several cycles to show a bus condition
  task bus(input start);
  begin
    if (start)
      bus_line_model_inst.start_cond;
    else
      bus_line_model_inst.stop_cond;
    repeat (10) @(posedge clk_i);
  end
  endtask

  // k 10 stands for a stop seen on the bus
  task err(input integer k, input [7:0] a, input [7:0] code, input [7:0] b);
  begin
    if (k == 10)
      bus(1'b0);
    else
      pulse(k);
    s1(a);
    wb(1'b0, 8'h08, 8'h00);
    chk("status_two", code, q);
    s1(b);
  end
  endtask

  task t_reset;
  begin
    s1(8'h00);
    wb(1'b0, 8'h20, 8'h00);
    chk("unmapped", 8'h00, q);
    $display("test reset done");
  end
  endtask

  task t_master;
  begin
    wb(1'b1, 8'h00, 8'h25);
    bus(1'b1);
    s1(8'h10);
    wb(1'b1, 8'h00, 8'h2d);
    s1(8'h12);
    chk("start_req", 8'h01, {7'h00, start_req});
    pulse(4);
    s1(8'h93);
    chk("start_req", 8'h00, {7'h00, start_req});
    chk("irq", 8'h01, {7'h00, irq_o});
    @(posedge clk_i) mask <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk("irq_masked", 8'h00, {7'h00, irq_o});
    @(posedge clk_i) mask <= 1'b0;
    wb(1'b1, 8'h0c, 8'ha0);
    s1(8'h12);
    pulse(0);
    @(negedge clk_i);
    chk("stretch", 8'h01, {7'h00, scl_oe_o});
    chk("scl_drive", 8'h00, {7'h00, scl_o});
    s1(8'hba);
    wb(1'b1, 8'h0c, 8'h55);
    s1(8'h12);
    chk("stretch", 8'h00, {7'h00, scl_oe_o});
    pulse(2);
    s1(8'hd2);
    wb(1'b1, 8'h0c, 8'h11);
    s1(8'hd2);
    wb(1'b0, 8'h08, 8'h00);
    wb(1'b1, 8'h0c, 8'h22);
    s1(8'h12);
    $display("test master done");
  end
  endtask

  task t_slave;
  begin
    // the last status read still arms the clear, so look first
    pulse(1);
    s1(8'h9a);
    wb(1'b0, 8'h0c, 8'h00);
    chk("data", 8'h5a, q);
    s1(8'h12);
    pulse(3);
    s1(8'h96);
    s1(8'h12);
    $display("test slave done");
  end
  endtask

  task t_errors;
  begin
    err(6, 8'h92, 8'h10, 8'h12);
    pulse(0);
    err(7, 8'h98, 8'h04, 8'h98);
    // byte done would hold the clock low and hide the next stop
    wb(1'b0, 8'h0c, 8'h00);
    chk("stretch", 8'h00, {7'h00, scl_oe_o});
    err(10, 8'h80, 8'h08, 8'h00);
    bus(1'b1);
    err(8, 8'h80, 8'h02, 8'h00);
    err(10, 8'h80, 8'h08, 8'h00);
    $display("test errors done");
  end
  endtask

  task t_disable;
  begin
    bus(1'b1);
    pulse(0);
    s1(8'hb8);
    wb(1'b1, 8'h00, 8'h12);
    s1(8'h10);
    chk("stretch", 8'h00, {7'h00, scl_oe_o});
    chk("stop_req", 8'h01, {7'h00, stop_req});
    chk("gcall_en", 8'h00, {7'h00, gcall_en});
    wb(1'b0, 8'h00, 8'h00);
    chk("ctrl", 8'h02, q);
    bus(1'b0);
    pulse(3);
    s1(8'h10);
    $display("test disable done");
  end
  endtask

  initial
  begin
    #400000;
    miscompares = miscompares + 1;
    stop_test;
  end

  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0000_0000;
    ev = 9'h000;
    rx_byte = 8'h5a;
    mask = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_master;
    t_slave;
    t_errors;
    t_disable;
    stop_test;
  end
endmodule

bind i2c_status_flag_logic i2c_flag_checker i2c_flag_checker_inst
(
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .scl_oe_o(scl_oe_o),
  .byte_tx_acked_i(byte_tx_acked_i), .byte_rx_acked_i(byte_rx_acked_i),
  .addr_match_i(addr_match_i), .rx_byte_i(rx_byte_i),
  .global_mask_i(global_mask_i), .tx_byte_o(tx_byte_o),
  .tx_load_o(tx_load_o), .rx_taken_o(rx_taken_o),
  .ack_enable_o(ack_enable_o), .iface_enable_o(iface_enable_o),
  .irq_o(irq_o)
);
